/* cpu_ack_model.sv */
// Behavioural CPU core that acknowledges offered interrupt requests
`timescale 1ns/1ps
`default_nettype none

module cpu_ack_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       int_req,
  input  wire logic [2:0] int_level,
  input  wire logic [7:0] int_vector,
  input  wire logic       int_fast,
  input  wire logic [3:0] ack_delay,
  output logic            service_acknowledge,
  output logic      [7:0] ack_count,
  output logic      [2:0] took_level,
  output logic      [7:0] took_vector,
  output logic            took_fast
);
  int wait_q;

  // ****************************************************************
  // Acknowledge handshake
  // ****************************************************************
  // Pulsed for one cycle; taken only if that edge sees the request still live
  always @(posedge clk_sys) begin
    if (reset) begin
      service_acknowledge <= #1 1'b0;
      ack_count <= 8'h00;
      wait_q <= 0;
    end else if (service_acknowledge) begin
      if (int_req) begin
        ack_count <= ack_count + 8'h01;
        took_level <= int_level;
        took_vector <= int_vector;
        took_fast <= int_fast;
      end
      service_acknowledge <= #1 1'b0;
      wait_q <= 0;
    end else if (int_req) begin
      if (wait_q >= ack_delay)
        service_acknowledge <= #1 1'b1;
      else
        wait_q <= wait_q + 1;
    end else
      wait_q <= 0;
  end
endmodule
`default_nettype wire

/* level_interrupt_controller.sv */
// Level interrupt controller: mask, group priority, request status and CPU handshake
// Summary of operation
// - Reset clears fast enable and global enable bits of the mode register.
// - Mode bits 4..2 select the fast level; not initialised by reset.
// - Enable instruction sets, disable instruction clears, global enable bit 0.
// - Mask bit n zero blocks level n, one lets it be serviced.
// - Mask register is read and written at offset DDH.
// - Priority register sits at FFH bank 0 and is not reset.
// - Highest priority level wins; lowest vector wins inside a level.
// - Levels 0,1 form group A; levels 5,6,7 form group C.
// - Priority bits 7,4,1 order groups; 001 gives B>C>A, 101 gives C>B>A.
// - Bit 5 orders level 5 against 6,7; bit 6 orders 6 against 7.
// - Priority bit 0 orders level 0 against level 1.
// - Request register at DCH shows one outstanding-request bit per level.
// - Request register is read only and cleared by reset.
// - Requests still record while global enable is off.
// - Hardware pending bit sets on event, requests CPU, clears on acknowledge.
// - Hardware pending bits have no register address.
// - Timer 0 overflow is hardware cleared; all other sources are software cleared.
// - Port 1 pins 0..3 request level 4, pins 4..7 level 5.
// - Timers 1,2 share level 1, serial ports level 2, watch timer level 3.
// - Levels 2,3,4 form group B.
// - Service needs global enable, unmasked level, top priority, enabled source.
// - Accepting an interrupt clears the global enable bit.
`timescale 1ns/1ps
`default_nettype none
`include "level_interrupt_controller_defs.svh"

module level_interrupt_controller #(
  parameter int NUM_LEVELS = 8,
  parameter int NUM_SRC    = `LIC_NUM_SRC
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_bank1,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  input  wire logic                enable_interrupts_instruction,
  input  wire logic                disable_interrupts_instruction,
  input  wire logic                iret_exec,
  input  wire logic [NUM_SRC-1:0]  src_pend,
  input  wire logic [NUM_SRC-1:0]  src_en,
  input  wire logic                service_acknowledge,
  output logic                     int_req,
  output logic      [2:0]          int_level,
  output logic      [7:0]          int_vector,
  output logic                     int_fast
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_LEVELS != 8 || NUM_SRC != `LIC_NUM_SRC) begin : g_bad_param
    $error("level_interrupt_controller: tables serve 8 levels and 17 sources only");
  end

  // ****************************************************************
  // Table lookups
  // ****************************************************************
  function automatic level_interrupt_controller_pkg::level_t src_level(input int s);
    logic [3*`LIC_NUM_SRC-1:0] tbl;
    tbl = `LIC_SRC_LEVELS;
    return tbl[3*s +: 3];
  endfunction
  function automatic logic [7:0] src_vector(input int s);
    logic [8*`LIC_NUM_SRC-1:0] tbl;
    tbl = `LIC_VECTORS;
    return tbl[8*s +: 8];
  endfunction

  // Eight levels, highest priority in the top three bits
  function automatic logic [23:0] level_order(input logic [7:0] prio);
    logic [5:0] ga;
    logic [5:0] b_sub;
    logic [5:0] c_sub;
    logic [8:0] gb;
    logic [8:0] gc;
    logic [2:0] code;
    ga    = prio[`LIC_PRI_A_SWAP] ? {3'h1, 3'h0} : {3'h0, 3'h1};
    b_sub = prio[`LIC_PRI_B_SUB] ? {3'h4, 3'h3} : {3'h3, 3'h4};
    gb    = prio[`LIC_PRI_B_HEAD] ? {b_sub, 3'h2} : {3'h2, b_sub};
    c_sub = prio[`LIC_PRI_C_SUB] ? {3'h7, 3'h6} : {3'h6, 3'h7};
    gc    = prio[`LIC_PRI_C_HEAD] ? {c_sub, 3'h5} : {3'h5, c_sub};
    code  = {prio[`LIC_PRI_GRP2], prio[`LIC_PRI_GRP1], prio[`LIC_PRI_GRP0]};
    case (code)
      3'h1:    level_order = {gb, gc, ga};
      3'h2:    level_order = {ga, gb, gc};
      3'h3:    level_order = {gb, ga, gc};
      3'h4:    level_order = {gc, ga, gb};
      3'h5:    level_order = {gc, gb, ga};
      3'h6:    level_order = {ga, gc, gb};
      // Undefined codes fall back to A > B > C
      default: level_order = {ga, gb, gc};
    endcase
  endfunction

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  logic                   gie_q;
  logic                   fie_q;
  logic [2:0]             fsel_q;
  logic [7:0]             mask_q;
  logic [7:0]             prio_q;
  logic [7:0]             level_request_q;
  logic                   t0_ovf_pend_q;
  logic [NUM_SRC-1:0]     eff;
  logic [7:0]             level_raw;
  logic [7:0]             cand;
  logic [23:0]            ord;
  logic                   win_found;
  level_interrupt_controller_pkg::level_t   win_level;
  level_interrupt_controller_pkg::src_idx_t win_src;
  level_interrupt_controller_pkg::src_idx_t int_src_q;
  level_interrupt_controller_pkg::service_state_t state_q;
  level_interrupt_controller_pkg::service_state_t state_d;
  logic                   mode_wr;
  logic                   mask_wr;
  logic                   prio_wr;
  logic                   ack_take;

  // Request register at DCH takes no writes
  assign mode_wr  = reg_wr && reg_addr == `LIC_ADDR_MODE;
  assign mask_wr  = reg_wr && reg_addr == `LIC_ADDR_MASK;
  assign prio_wr  = reg_wr && reg_addr == `LIC_ADDR_PRIORITY && !reg_bank1;
  assign ack_take = service_acknowledge && state_q == level_interrupt_controller_pkg::ST_REQ;

  // Acknowledge beats every software action on the enable bit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gie_q <= 1'b0;
    end else if (ack_take) begin
      gie_q <= 1'b0;
    end else if (enable_interrupts_instruction || iret_exec) begin
      gie_q <= 1'b1;
    end else if (disable_interrupts_instruction) begin
      gie_q <= 1'b0;
    end else if (mode_wr) begin
      gie_q <= reg_wdata[`LIC_MODE_GIE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fie_q <= 1'b0;
    end else if (mode_wr) begin
      fie_q <= reg_wdata[`LIC_MODE_FIE];
    end
  end

  // Left without reset on purpose: software must program these
  always_ff @(posedge clk_sys) begin
    if (mode_wr) begin
      fsel_q <= reg_wdata[`LIC_MODE_FSEL_MSB:`LIC_MODE_FSEL_LSB];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (mask_wr) begin
      mask_q <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (prio_wr) begin
      prio_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= `LIC_RDATA_RESET;
    end else begin
      case (reg_addr)
        `LIC_ADDR_REQUEST:  reg_rdata <= level_request_q;
        `LIC_ADDR_MASK:     reg_rdata <= mask_q;
        `LIC_ADDR_MODE:     reg_rdata <= {3'h0, fsel_q, fie_q, gie_q};
        `LIC_ADDR_PRIORITY: reg_rdata <= reg_bank1 ? 8'h00 : prio_q;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Pending bits and level requests
  // ****************************************************************
  // Unmapped: no decode reaches it; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      t0_ovf_pend_q <= 1'b0;
    end else if (src_pend[`LIC_HW_SRC]) begin
      t0_ovf_pend_q <= 1'b1;
    end else if (ack_take && int_src_q == 5'(`LIC_HW_SRC)) begin
      t0_ovf_pend_q <= 1'b0;
    end
  end

  // Other pending bits live in the peripherals and are cleared there
  always_comb begin
    eff = src_pend & src_en;
    eff[`LIC_HW_SRC] = t0_ovf_pend_q && src_en[`LIC_HW_SRC];
  end

  for (genvar n = 0; n < NUM_LEVELS; n++) begin : g_level
    logic [NUM_SRC-1:0] members;
    always_comb begin
      members = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
        members[s] = src_level(s) == 3'(n);
      end
    end
    assign level_raw[n] = |(eff & members);
  end

  // Records regardless of global enable so polling sees every event of an enabled source
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_request_q <= `LIC_REQUEST_RESET;
    end else begin
      level_request_q <= level_raw;
    end
  end

  // ****************************************************************
  // Priority resolution
  // ****************************************************************
  assign cand = level_request_q & mask_q & {8{gie_q}};
  assign ord  = level_order(prio_q);

  always_comb begin
    win_found = 1'b0;
    win_level = 3'h0;
    win_src   = 5'h0;
    for (int i = 0; i < 8; i++) begin
      if (!win_found && cand[ord[23-3*i -: 3]]) begin
        win_found = 1'b1;
        win_level = ord[23-3*i -: 3];
      end
    end
    // Downward scan leaves the lowest index, hence lowest vector
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (eff[s] && src_level(s) == win_level) begin
        win_src = 5'(s);
      end
    end
  end

  // ****************************************************************
  // CPU handshake
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      level_interrupt_controller_pkg::ST_IDLE: begin
        if (win_found) begin
          state_d = level_interrupt_controller_pkg::ST_REQ;
        end
      end
      level_interrupt_controller_pkg::ST_REQ: begin
        if (ack_take) begin
          state_d = level_interrupt_controller_pkg::ST_SERVE;
        end else if (!win_found) begin
          state_d = level_interrupt_controller_pkg::ST_IDLE;
        end
      end
      level_interrupt_controller_pkg::ST_SERVE: begin
        if (gie_q) begin
          state_d = level_interrupt_controller_pkg::ST_IDLE;
        end
      end
      default: state_d = level_interrupt_controller_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= level_interrupt_controller_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign int_req = state_q == level_interrupt_controller_pkg::ST_REQ;
  // Frozen while serving so the CPU sees a stable vector
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_level  <= 3'h0;
      int_vector <= 8'h00;
      int_fast   <= 1'b0;
      int_src_q  <= 5'h0;
    end else if (state_d != level_interrupt_controller_pkg::ST_SERVE) begin
      int_level  <= win_level;
      int_vector <= src_vector(int'(win_src));
      int_fast   <= fie_q && fsel_q == win_level;
      int_src_q  <= win_src;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [7:0] cand_q;
  always_ff @(posedge clk_sys) begin
    cand_q <= cand;
  end
  property p_reset_mode;
    @(posedge clk_sys) reset |=> !gie_q && !fie_q;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("enable bits not cleared");
  property p_set_gie;
    @(posedge clk_sys) disable iff (reset) enable_interrupts_instruction && !ack_take |=> gie_q;
  endproperty
  a_set_gie: assert property (p_set_gie) else $error("enable instruction ignored");
  property p_clr_gie;
    @(posedge clk_sys) disable iff (reset)
      disable_interrupts_instruction && !enable_interrupts_instruction && !iret_exec
        |=> !gie_q ##1 (!gie_q || $past(enable_interrupts_instruction)
        || $past(iret_exec) || $past(mode_wr));
  endproperty
  a_clr_gie: assert property (p_clr_gie) else $error("disable instruction ignored");
  property p_mask;
    @(posedge clk_sys) disable iff (reset)
      mask_q == 8'h00 && !mask_wr |=> !$rose(int_req);
  endproperty
  a_mask: assert property (p_mask) else $error("masked level requested");
  property p_req_reset;
    @(posedge clk_sys) reset |=> level_request_q == `LIC_REQUEST_RESET ##1 reg_rdata == 8'h00
      || reg_addr != `LIC_ADDR_REQUEST || level_request_q != 8'h00;
  endproperty
  a_req_reset: assert property (p_req_reset) else $error("request status not reset");
  property p_poll;
    @(posedge clk_sys) disable iff (reset)
      !gie_q && src_pend[0] && src_en[0] |=> level_request_q[0];
  endproperty
  a_poll: assert property (p_poll) else $error("request lost while disabled");
  property p_ack_gie;
    @(posedge clk_sys) disable iff (reset)
      ack_take |=> !gie_q && !int_req;
  endproperty
  a_ack_gie: assert property (p_ack_gie) else $error("enable survives acknowledge");
  property p_hw_set;
    @(posedge clk_sys) disable iff (reset) src_pend[`LIC_HW_SRC] |=> t0_ovf_pend_q [*1];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("overflow event lost");
  property p_hw_clr;
    @(posedge clk_sys) disable iff (reset)
      ack_take && int_src_q == 5'(`LIC_HW_SRC) && !src_pend[`LIC_HW_SRC] |=> !t0_ovf_pend_q;
  endproperty
  a_hw_clr: assert property (p_hw_clr) else $error("hardware pending not cleared");
  property p_win;
    @(posedge clk_sys) disable iff (reset) $rose(int_req) |-> cand_q[int_level];
  endproperty
  a_win: assert property (p_win) else $error("request for ineligible level");

  c_ack:  cover property (@(posedge clk_sys) disable iff (reset) ack_take ##[1:20] iret_exec);
  c_fast: cover property (@(posedge clk_sys) disable iff (reset) int_req && int_fast);
  c_hw:   cover property (@(posedge clk_sys) disable iff (reset)
    ack_take && int_src_q == 5'(`LIC_HW_SRC));

endmodule
`default_nettype wire

/* level_interrupt_controller_defs.svh */
// Register map, field positions and constant tables of the level interrupt controller
`ifndef LEVEL_INTERRUPT_CONTROLLER_DEFS_SVH
`define LEVEL_INTERRUPT_CONTROLLER_DEFS_SVH

// ****************************************************************
// Register offsets in register set 1
// ****************************************************************
`define LIC_ADDR_REQUEST   8'hDC
`define LIC_ADDR_MASK      8'hDD
`define LIC_ADDR_MODE      8'hDE
`define LIC_ADDR_PRIORITY  8'hFF

// ****************************************************************
// Reset values
// ****************************************************************
`define LIC_REQUEST_RESET  8'h00
`define LIC_RDATA_RESET    8'h00

// ****************************************************************
// System mode register fields
// ****************************************************************
`define LIC_MODE_GIE       0
`define LIC_MODE_FIE       1
`define LIC_MODE_FSEL_LSB  2
`define LIC_MODE_FSEL_MSB  4

// ****************************************************************
// Level priority register fields
// ****************************************************************
`define LIC_PRI_A_SWAP     0
`define LIC_PRI_GRP0       1
`define LIC_PRI_B_HEAD     2
`define LIC_PRI_B_SUB      3
`define LIC_PRI_GRP1       4
`define LIC_PRI_C_HEAD     5
`define LIC_PRI_C_SUB      6
`define LIC_PRI_GRP2       7

// ****************************************************************
// Source tables, index 0 in the low bits, lowest vector first in a level
// ****************************************************************
`define LIC_NUM_SRC        17
`define LIC_HW_SRC         1
`define LIC_VECTORS {8'hC2, 8'hC0, 8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD4, 8'hD2, \
  8'hD0, 8'hF2, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0}
`define LIC_SRC_LEVELS {3'h7, 3'h6, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4, \
  3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0}

`endif

/* level_interrupt_controller_pkg.sv */
// Types shared by the level interrupt controller
package level_interrupt_controller_pkg;
  typedef logic [2:0] level_t;
  typedef logic [4:0] src_idx_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_REQ   = 2'h1,
    ST_SERVE = 2'h3
  } service_state_t;
endpackage

/* level_interrupt_controller_test.sv */
// Self-checking bench of the level interrupt controller against a behavioural model
`timescale 1ns/1ps
`default_nettype none

module level_interrupt_controller_test;
  logic        clk_sys = 1'b0;
  logic        reset;
  logic [7:0]  reg_addr;
  logic        reg_bank1;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        enable_interrupts_instruction;
  logic        disable_interrupts_instruction;
  logic        iret_exec;
  logic [16:0] src_pend;
  logic [16:0] src_en;
  logic        service_acknowledge;
  logic        int_req;
  logic [2:0]  int_level;
  logic [7:0]  int_vector;
  logic        int_fast;
  logic [3:0]  ack_delay;
  logic [7:0]  ack_count;
  logic [2:0]  took_level;
  logic [7:0]  took_vector;
  logic        took_fast;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed = 32'hD7A1;

  always #12.5 clk_sys = ~clk_sys;

  level_interrupt_controller level_interrupt_controller_i (.clk_sys, .reset, .reg_addr,
    .reg_bank1, .reg_wr, .reg_wdata, .reg_rdata, .enable_interrupts_instruction,
    .disable_interrupts_instruction, .iret_exec, .src_pend, .src_en, .service_acknowledge,
    .int_req, .int_level, .int_vector, .int_fast);

  cpu_ack_model cpu_ack_model_i (.clk_sys, .reset, .int_req, .int_level, .int_vector,
    .int_fast, .ack_delay, .service_acknowledge, .ack_count, .took_level, .took_vector,
    .took_fast);

  // ****************************************************************
  // Reference model
  // ****************************************************************
  function automatic int lvl_of(input int s);
    if (s < 6) return s / 2;
    if (s == 6) return 3;
    if (s < 11) return 4;
    if (s < 15) return 5;
    return s - 9;
  endfunction

  function automatic int vec_of(input int s);
    if (s < 6) return 'hE0 + 2 * s;
    if (s == 6) return 'hF2;
    if (s < 15) return 'hD0 + 2 * (s - 7);
    return 'hC0 + 2 * (s - 15);
  endfunction

  // Builds the full level order, then returns the first active level
  function automatic int pick(input logic [7:0] act, input logic [7:0] p);
    int a[$];
    int b[$];
    int c[$];
    int o[$];
    if (p[0]) a = '{1, 0};
    else a = '{0, 1};
    if (p[3]) b = '{4, 3};
    else b = '{3, 4};
    if (p[2]) b.push_back(2);
    else b.push_front(2);
    if (p[6]) c = '{7, 6};
    else c = '{6, 7};
    if (p[5]) c.push_back(5);
    else c.push_front(5);
    case ({p[7], p[4], p[1]})
      3'h1: o = {b, c, a};
      3'h3: o = {b, a, c};
      3'h4: o = {c, a, b};
      3'h5: o = {c, b, a};
      3'h6: o = {a, c, b};
      default: o = {a, b, c};
    endcase
    foreach (o[i])
      if (act[o[i]]) return o[i];
    return -1;
  endfunction

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b1);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_bank1 = b1;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_bank1 = 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    cmp(nm, e, reg_rdata & m);
  endtask

  // Kind 0 enable, 1 disable, 2 return
  task automatic instr(input int k);
    @(posedge clk_sys);
    #1;
    {iret_exec, disable_interrupts_instruction, enable_interrupts_instruction} = 3'(1 << k);
    @(posedge clk_sys);
    #1;
    {iret_exec, disable_interrupts_instruction, enable_interrupts_instruction} = 3'h0;
  endtask

  task automatic wait_ack(input logic [7:0] n0);
    for (int i = 0; i < 16 && ack_count === n0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp("ack_count", n0 + 8'h01, ack_count);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] msk;
    logic [7:0] pri;
    logic [7:0] req;
    logic [7:0] n0;
    logic [7:0] vec;
    logic [2:0] fs;
    logic       fie;
    int         win;
    {reset, reg_addr, reg_bank1, reg_wr, reg_wdata} = {1'b1, 18'h0};
    {enable_interrupts_instruction, disable_interrupts_instruction, iret_exec} = 3'h0;
    {src_pend, src_en, ack_delay} = 38'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    rchk("request_status", 8'hDC, 8'hFF, 8'h00);
    rchk("system_mode", 8'hDE, 8'hE3, 8'h00);
    cmp("int_req", 8'h00, int_req);
    wr(8'hDD, 8'h5A, 1'b0);
    rchk("level_mask", 8'hDD, 8'hFF, 8'h5A);
    wr(8'hFF, 8'h3C, 1'b0);
    wr(8'hFF, 8'hC3, 1'b1);
    rchk("level_priority", 8'hFF, 8'hFF, 8'h3C);
    wr(8'hDC, 8'hFF, 1'b0);
    rchk("request_status", 8'hDC, 8'hFF, 8'h00);
    rchk("unmapped", 8'hDB, 8'hFF, 8'h00);
    wr(8'hDE, 8'hFC, 1'b0);
    rchk("system_mode", 8'hDE, 8'hFF, 8'h1C);
    instr(0);
    rchk("global_enable", 8'hDE, 8'h01, 8'h01);
    instr(1);
    rchk("global_enable", 8'hDE, 8'h01, 8'h00);
    wr(8'hDE, 8'h01, 1'b0);
    rchk("global_enable", 8'hDE, 8'h01, 8'h01);
    wr(8'hDE, 8'h00, 1'b0);
    rchk("global_enable", 8'hDE, 8'h01, 8'h00);
    // Hardware-cleared overflow source, then a software-cleared one on the same level
    wr(8'hDD, 8'hFF, 1'b0);
    wr(8'hFF, 8'h00, 1'b0);
    src_en = 17'h00003;
    src_pend = 17'h00002;
    @(posedge clk_sys);
    #1;
    src_pend = 17'h00000;
    repeat (2) @(posedge clk_sys);
    rchk("request_status", 8'hDC, 8'hFF, 8'h01);
    n0 = ack_count;
    instr(0);
    wait_ack(n0);
    cmp("took_vector", 8'hE2, took_vector);
    repeat (2) @(posedge clk_sys);
    rchk("request_status", 8'hDC, 8'hFF, 8'h00);
    src_pend = 17'h00001;
    n0 = ack_count;
    instr(2);
    wait_ack(n0);
    cmp("took_vector", 8'hE0, took_vector);
    repeat (2) @(posedge clk_sys);
    rchk("request_status", 8'hDC, 8'hFF, 8'h01);
    src_pend = 17'h00000;
    // Random rounds walking every group order code
    for (int r = 0; r < 40; r++) begin
      instr(1);
      msk = 8'($random(seed));
      if (r == 5) msk = 8'h00;
      pri = 8'($random(seed));
      {pri[7], pri[4], pri[1]} = 3'(r);
      fs = 3'($random(seed));
      fie = 1'($random(seed));
      wr(8'hDD, msk, 1'b0);
      wr(8'hFF, pri, 1'b0);
      wr(8'hDE, {3'h0, fs, fie, 1'b0}, 1'b0);
      src_en = 17'($random(seed));
      src_pend = 17'($random(seed) & $random(seed)) & ~17'h00002;
      ack_delay = 4'($random(seed)) & 4'h3;
      req = 8'h00;
      vec = 8'h00;
      for (int s = 0; s < 17; s++)
        if (src_pend[s] && src_en[s]) req[lvl_of(s)] = 1'b1;
      repeat (3) @(posedge clk_sys);
      rchk("request_status", 8'hDC, 8'hFF, req);
      cmp("int_req", 8'h00, int_req);
      win = pick(req & msk, pri);
      for (int s = 16; s >= 0; s--)
        if (src_pend[s] && src_en[s] && lvl_of(s) == win) vec = 8'(vec_of(s));
      n0 = ack_count;
      instr(0);
      if (win < 0) begin
        repeat (4) @(posedge clk_sys);
        #1;
        cmp("int_req", 8'h00, int_req);
      end else begin
        wait_ack(n0);
        cmp("took_level", 8'(win), {5'h0, took_level});
        cmp("took_vector", vec, took_vector);
        cmp("took_fast", {7'h0, fie && (fs == 3'(win))}, {7'h0, took_fast});
        cmp("int_req", 8'h00, int_req);
        rchk("global_enable", 8'hDE, 8'h01, 8'h00);
      end
      src_pend = 17'h00000;
      instr(2);
    end
    wrap_up();
  end

  initial begin
    #(25.0 * 20000);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
